//--- cks_pkg.sv
// constants, field layouts and state encodings of the clock source block
// assumes nothing; shared by the clock control top, its checker and the testbench
package cks_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] ADDR_CTRL     = 3'h0;
  localparam logic [2:0] ADDR_CFG      = 3'h1;
  localparam logic [2:0] ADDR_IRQ_STS  = 3'h2;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
  localparam logic [2:0] ADDR_STATUS   = 3'h4;

  // oscillator_control_reg fields
  localparam int CTRL_SCS_BIT  = 0;
  localparam int CTRL_EXT_BIT  = 1;
  localparam int CTRL_LTS_BIT  = 2;
  localparam int CTRL_HTS_BIT  = 3;
  localparam int CTRL_INTERNAL_FREQ_SELECT_LSB = 4;

  // status register fields
  localparam int STAT_EXT_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_FAIL_BIT  = 2;
  localparam int STAT_XRDY_BIT  = 3;
  localparam int STAT_FAST_BIT  = 4;
  localparam int STAT_SLOW_BIT  = 5;

  // fuse word fields
  localparam int FUSE_MODE_LSB = 0;
  localparam int FUSE_TWO_SPEED_STARTUP_ENABLE_BIT = 3;
  localparam int FUSE_CLOCK_FAIL_MONITOR_BIT = 4;
  localparam int FUSE_POWER_UP_TIMER_BIT = 5;
  localparam int FUSE_WDT_BIT  = 6;

  // interrupt status and mask layout
  localparam int IRQ_FAIL_BIT   = 0;
  localparam int IRQ_SWITCH_BIT = 1;
  localparam int IRQ_LSTAB_BIT  = 2;
  localparam int IRQ_WIDTH      = 3;

  // reset values and frequency codes
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h6;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_SLOW  = 3'h0;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_FAST  = 3'h7;
  localparam logic [7:0] FUSE_RESET = 8'h00;

  // oscillator start-up delay in edges of the started oscillator
  localparam logic [7:0] START_EDGES = 8'h10;
  // slow ticks without an external edge before the clock counts as lost
  localparam logic [1:0] FAIL_TICKS  = 2'h3;

  typedef enum logic [2:0] {
    MODE_LP    = 3'b000,
    MODE_XT    = 3'b001,
    MODE_HS    = 3'b010,
    MODE_INTIO = 3'b011,
    MODE_INTCK = 3'b100,
    MODE_EC    = 3'b101,
    MODE_RESISTOR_CAPACITOR_PIN_IO_MODE  = 3'b110,
    MODE_RCCK  = 3'b111
  } cks_mode_t;

  typedef enum logic [1:0] {
    GAIN_OFF  = 2'b00,
    GAIN_LOW  = 2'b01,
    GAIN_MED  = 2'b10,
    GAIN_HIGH = 2'b11
  } cks_gain_t;

  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_START = 2'b01,
    SW_FALL  = 2'b10,
    SW_LOW   = 2'b11
  } cks_sw_state_t;

endpackage

//--- cks_edge_if.sv
// level and edge pulses of one synchronised clock signal
// assumes the producer runs on core_clk
`timescale 1ns/1ps
interface cks_edge_if;
  logic lvl;
  logic rise;
  logic fall;
  modport drv (output lvl, output rise, output fall);
  modport use_ (input lvl, input rise, input fall);
endinterface

//--- cks_edge_sync.sv
// two-flop synchroniser with edge detection for an oscillator signal
// assumes the raw input is asynchronous to core_clk
`timescale 1ns/1ps
module cks_edge_sync (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // raw oscillator level
  input  wire logic   raw_in,
  // synchronised level and edges
  cks_edge_if.drv     edge_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign edge_o.lvl  = sync_r;
  assign edge_o.rise = sync_r & ~prev_r;
  assign edge_o.fall = ~sync_r & prev_r;

endmodule

//--- cks_clock_ctrl.sv
// oscillator mode decode, internal clock postscaler, fail monitor and
// glitch-free clock switch with register port and interrupt
// assumes oscillator signals arrive asynchronous and slower than core_clk / 2
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module cks_clock_ctrl (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // fuse word, caught after reset release
  input  wire logic [7:0] fuse_word,
  // oscillator signals
  input  wire logic       ext_clk_in,
  input  wire logic       fast_osc_in,
  input  wire logic       slow_osc_in,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // oscillator and pin control
  output logic      [1:0] xtal_gain,
  output logic            fast_osc_en,
  output logic            slow_osc_en,
  output logic            first_pin_io_free,
  output logic            second_pin_io_free,
  output logic            second_pin_out,
  output logic            second_pin_oe_n,
  // clocks
  output logic            sys_clk_out,
  output logic            slow_tick,
  // interrupt
  output logic            irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised oscillator edges

  cks_edge_if ext_e ();
  cks_edge_if fast_e ();
  cks_edge_if slow_e ();

  cks_edge_sync u_ext_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .raw_in   (ext_clk_in),
    .edge_o   (ext_e)
  );

  cks_edge_sync u_fast_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .raw_in   (fast_osc_in),
    .edge_o   (fast_e)
  );

  cks_edge_sync u_slow_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .raw_in   (slow_osc_in),
    .edge_o   (slow_e)
  );

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]                fuse_r;
  logic                      fuse_loaded_r;
  logic                      scs_r;
  logic [2:0]                internal_freq_select_r;
  logic [cks_pkg::IRQ_WIDTH-1:0] irq_sts_r;
  logic [cks_pkg::IRQ_WIDTH-1:0] irq_mask_r;
  logic [cks_pkg::IRQ_WIDTH-1:0] irq_ev;
  cks_pkg::cks_sw_state_t    sw_state_r;
  logic                      act_ext_r;
  logic [2:0]                act_internal_freq_select_r;
  logic                      tgt_ext_r;
  logic [2:0]                tgt_internal_freq_select_r;
  logic [5:0]                pscl_r;
  logic [7:0]                fast_cnt_r;
  logic [7:0]                slow_cnt_r;
  logic [7:0]                ext_cnt_r;
  logic [1:0]                fail_cnt_r;
  logic                      fail_r;
  logic                      cur_prev_r;
  logic                      new_prev_r;
  logic                      sys_prev_r;
  logic [1:0]                div4_r;
  logic                      lts_r;
  logic                      hts_r;
  logic                      lts_prev_r;

  cks_pkg::cks_mode_t        mode;
  logic                      mode_ext;
  logic                      mode_int;
  logic                      two_speed_startup_enable;
  logic                      req_ext;
  logic                      cur_lvl;
  logic                      new_lvl;
  logic                      new_rise;
  logic                      cur_fall;
  logic                      fast_ready;
  logic                      slow_ready;
  logic                      ext_ready;
  logic                      tgt_ready;
  logic                      fast_need;
  logic                      slow_need;
  logic                      gate_low;
  logic                      switch_done;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  always_comb
  begin
    mode     = cks_cast(fuse_r[cks_pkg::FUSE_MODE_LSB +: 3]);
    mode_int = (mode == cks_pkg::MODE_INTIO) || (mode == cks_pkg::MODE_INTCK);
    mode_ext = fuse_loaded_r && !mode_int;
    two_speed_startup_enable     = fuse_r[cks_pkg::FUSE_TWO_SPEED_STARTUP_ENABLE_BIT];
  end

  function automatic cks_pkg::cks_mode_t cks_cast(input logic [2:0] code);
    cks_cast = cks_pkg::cks_mode_t'(code);
  endfunction

  // level of a source: external pin, fast oscillator, postscaler tap or slow
  function automatic logic src_lvl(input logic ext, input logic [2:0] f,
                                   input logic xl, input logic fl,
                                   input logic sl, input logic [5:0] ps);
    if (ext)
      src_lvl = xl;
    else
    begin
      case (f)
        3'h7:    src_lvl = fl;
        3'h6:    src_lvl = ps[0];
        3'h5:    src_lvl = ps[1];
        3'h4:    src_lvl = ps[2];
        3'h3:    src_lvl = ps[3];
        3'h2:    src_lvl = ps[4];
        3'h1:    src_lvl = ps[5];
        default: src_lvl = sl;
      endcase
    end
  endfunction

  // a source is fast-based for codes 001 to 111
  function automatic logic uses_fast(input logic ext, input logic [2:0] f);
    uses_fast = !ext && (f != cks_pkg::INTERNAL_FREQ_SELECT_SLOW);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fuse capture and software registers

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fuse_r        <= cks_pkg::FUSE_RESET;
      fuse_loaded_r <= 1'b0;
    end
    else if (!fuse_loaded_r)
    begin
      fuse_r        <= fuse_word;
      fuse_loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      scs_r      <= 1'b0;
      internal_freq_select_r     <= cks_pkg::INTERNAL_FREQ_SELECT_RESET;
      irq_mask_r <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == cks_pkg::ADDR_CTRL)
      begin
        scs_r  <= reg_wdata[cks_pkg::CTRL_SCS_BIT];
        internal_freq_select_r <= reg_wdata[cks_pkg::CTRL_INTERNAL_FREQ_SELECT_LSB +: 3];
      end
      if (reg_addr == cks_pkg::ADDR_IRQ_MASK)
        irq_mask_r <= reg_wdata[cks_pkg::IRQ_WIDTH-1:0];
    end
  end

  // events set, write-one clears; a set in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq_sts_r <= '0;
    else if (reg_wr && (reg_addr == cks_pkg::ADDR_IRQ_STS))
      irq_sts_r <= (irq_sts_r & ~reg_wdata[cks_pkg::IRQ_WIDTH-1:0]) | irq_ev;
    else
      irq_sts_r <= irq_sts_r | irq_ev;
  end

  always_comb
  begin
    irq_ev = '0;
    irq_ev[cks_pkg::IRQ_FAIL_BIT]   = (fail_cnt_r == cks_pkg::FAIL_TICKS) && !fail_r
                                      && slow_e.rise && !ext_e.rise;
    irq_ev[cks_pkg::IRQ_SWITCH_BIT] = switch_done;
    irq_ev[cks_pkg::IRQ_LSTAB_BIT]  = lts_r && !lts_prev_r;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        cks_pkg::ADDR_CTRL:
          reg_rdata <= {1'b0, internal_freq_select_r, hts_r, lts_r, act_ext_r, scs_r};
        cks_pkg::ADDR_CFG:
          reg_rdata <= fuse_r;
        cks_pkg::ADDR_IRQ_STS:
          reg_rdata <= {5'h00, irq_sts_r};
        cks_pkg::ADDR_IRQ_MASK:
          reg_rdata <= {5'h00, irq_mask_r};
        cks_pkg::ADDR_STATUS:
          reg_rdata <= {2'h0, slow_osc_en, fast_osc_en, ext_ready, fail_r,
                        (sw_state_r != cks_pkg::SW_IDLE), act_ext_r};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_sts_r & irq_mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator enables and start-up counters

  always_comb
  begin
    fast_need = uses_fast(act_ext_r, act_internal_freq_select_r)
                || ((sw_state_r != cks_pkg::SW_IDLE) && uses_fast(tgt_ext_r, tgt_internal_freq_select_r));
    slow_need = ((internal_freq_select_r == cks_pkg::INTERNAL_FREQ_SELECT_SLOW) && scs_r)
                || (two_speed_startup_enable && (internal_freq_select_r == cks_pkg::INTERNAL_FREQ_SELECT_SLOW))
                || fuse_r[cks_pkg::FUSE_POWER_UP_TIMER_BIT] || fuse_r[cks_pkg::FUSE_WDT_BIT]
                || fuse_r[cks_pkg::FUSE_CLOCK_FAIL_MONITOR_BIT]
                || (!act_ext_r && (act_internal_freq_select_r == cks_pkg::INTERNAL_FREQ_SELECT_SLOW))
                || ((sw_state_r != cks_pkg::SW_IDLE) && !tgt_ext_r
                    && (tgt_internal_freq_select_r == cks_pkg::INTERNAL_FREQ_SELECT_SLOW));
    fast_ready = (fast_cnt_r == cks_pkg::START_EDGES);
    slow_ready = (slow_cnt_r == cks_pkg::START_EDGES);
    ext_ready  = (ext_cnt_r == cks_pkg::START_EDGES);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fast_osc_en <= 1'b0;
      slow_osc_en <= 1'b0;
    end
    else
    begin
      fast_osc_en <= fast_need;
      slow_osc_en <= slow_need;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fast_cnt_r <= 8'h00;
      slow_cnt_r <= 8'h00;
      ext_cnt_r  <= 8'h00;
    end
    else
    begin
      if (!fast_osc_en)
        fast_cnt_r <= 8'h00;
      else if (fast_e.rise && !fast_ready)
        fast_cnt_r <= fast_cnt_r + 8'h01;
      if (!slow_osc_en)
        slow_cnt_r <= 8'h00;
      else if (slow_e.rise && !slow_ready)
        slow_cnt_r <= slow_cnt_r + 8'h01;
      if (!mode_ext || fail_r)
        ext_cnt_r <= 8'h00;
      else if (ext_e.rise && !ext_ready)
        ext_cnt_r <= ext_cnt_r + 8'h01;
    end
  end

  // postscaler on the fast oscillator gives the 4 MHz to 125 kHz taps
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pscl_r <= 6'h00;
    else if (fast_e.rise)
      pscl_r <= pscl_r + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fail monitor on the slow timebase

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fail_cnt_r <= 2'h0;
      fail_r     <= 1'b0;
    end
    else if (ext_e.rise || !mode_ext || !fuse_r[cks_pkg::FUSE_CLOCK_FAIL_MONITOR_BIT])
      fail_cnt_r <= 2'h0;
    else if (slow_e.rise)
    begin
      if (fail_cnt_r == cks_pkg::FAIL_TICKS)
        fail_r <= 1'b1;
      else
        fail_cnt_r <= fail_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      slow_tick <= 1'b0;
    else
      slow_tick <= slow_e.rise && slow_osc_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock switch

  always_comb
  begin
    req_ext = mode_ext && !scs_r && !fail_r;
    cur_lvl = src_lvl(act_ext_r, act_internal_freq_select_r, ext_e.lvl, fast_e.lvl, slow_e.lvl, pscl_r);
    new_lvl = src_lvl(tgt_ext_r, tgt_internal_freq_select_r, ext_e.lvl, fast_e.lvl, slow_e.lvl, pscl_r);
    new_rise = new_lvl && !new_prev_r;
    cur_fall = !cur_lvl && cur_prev_r;
    tgt_ready = tgt_ext_r ? ext_ready
              : (tgt_internal_freq_select_r == cks_pkg::INTERNAL_FREQ_SELECT_SLOW) ? slow_ready : fast_ready;
    switch_done = (sw_state_r == cks_pkg::SW_LOW) && new_rise;
    // without two-speed start the core waits for the external oscillator
    gate_low = req_ext && !act_ext_r && !two_speed_startup_enable;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cur_prev_r <= 1'b0;
      new_prev_r <= 1'b0;
    end
    else
    begin
      cur_prev_r <= cur_lvl;
      new_prev_r <= new_lvl;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sw_state_r <= cks_pkg::SW_IDLE;
      act_ext_r  <= 1'b0;
      act_internal_freq_select_r <= cks_pkg::INTERNAL_FREQ_SELECT_RESET;
      tgt_ext_r  <= 1'b0;
      tgt_internal_freq_select_r <= cks_pkg::INTERNAL_FREQ_SELECT_RESET;
    end
    else
    begin
      case (sw_state_r)
        cks_pkg::SW_IDLE:
          if ((req_ext != act_ext_r) || (!req_ext && (internal_freq_select_r != act_internal_freq_select_r)))
          begin
            tgt_ext_r  <= req_ext;
            tgt_internal_freq_select_r <= internal_freq_select_r;
            sw_state_r <= cks_pkg::SW_START;
          end
        cks_pkg::SW_START:
          if (tgt_ready || (uses_fast(tgt_ext_r, tgt_internal_freq_select_r)
                            && uses_fast(act_ext_r, act_internal_freq_select_r)))
            sw_state_r <= cks_pkg::SW_FALL;
        cks_pkg::SW_FALL:
          if (cur_fall || (fail_r && act_ext_r))
            sw_state_r <= cks_pkg::SW_LOW;
        cks_pkg::SW_LOW:
          if (new_rise)
          begin
            act_ext_r  <= tgt_ext_r;
            act_internal_freq_select_r <= tgt_internal_freq_select_r;
            sw_state_r <= cks_pkg::SW_IDLE;
          end
        default:
          sw_state_r <= cks_pkg::SW_IDLE;
      endcase
    end
  end

  // output follows the active clock, held low from old fall to new rise
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sys_clk_out <= 1'b0;
    else if ((sw_state_r == cks_pkg::SW_LOW) || gate_low)
      sys_clk_out <= 1'b0;
    else
      sys_clk_out <= cur_lvl;
  end

  // stable flags follow readiness, taken over when a switch completes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lts_r      <= 1'b0;
      hts_r      <= 1'b0;
      lts_prev_r <= 1'b0;
    end
    else
    begin
      lts_prev_r <= lts_r;
      if (switch_done)
      begin
        hts_r <= uses_fast(tgt_ext_r, tgt_internal_freq_select_r) && fast_ready;
        lts_r <= slow_ready;
      end
      else
      begin
        hts_r <= fast_need && fast_osc_en && fast_ready;
        lts_r <= slow_need && slow_osc_en && slow_ready;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_prev_r <= 1'b0;
      div4_r     <= 2'h0;
    end
    else
    begin
      sys_prev_r <= sys_clk_out;
      if (sys_clk_out && !sys_prev_r)
        div4_r <= div4_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      xtal_gain          <= cks_pkg::GAIN_OFF;
      first_pin_io_free  <= 1'b0;
      second_pin_io_free <= 1'b0;
      second_pin_out     <= 1'b0;
      second_pin_oe_n    <= 1'b1;
    end
    else
    begin
      case (mode)
        cks_pkg::MODE_LP: xtal_gain <= cks_pkg::GAIN_LOW;
        cks_pkg::MODE_XT: xtal_gain <= cks_pkg::GAIN_MED;
        cks_pkg::MODE_HS: xtal_gain <= cks_pkg::GAIN_HIGH;
        default:          xtal_gain <= cks_pkg::GAIN_OFF;
      endcase
      first_pin_io_free  <= fuse_loaded_r && mode_int;
      second_pin_io_free <= fuse_loaded_r && ((mode == cks_pkg::MODE_EC)
                            || (mode == cks_pkg::MODE_RESISTOR_CAPACITOR_PIN_IO_MODE)
                            || (mode == cks_pkg::MODE_INTIO));
      second_pin_out     <= div4_r[1];
      second_pin_oe_n    <= !(fuse_loaded_r && ((mode == cks_pkg::MODE_RCCK)
                            || (mode == cks_pkg::MODE_INTCK)));
    end
  end

endmodule

//--- cks_clock_ctrl_checker.sv
// port assertions for the clock control top
// assumes fuse_word is held steady between resets
`timescale 1ns/1ps
module cks_clock_ctrl_checker (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // fuse and register port
  input wire logic [7:0] fuse_word,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and clocks
  input wire logic [1:0] xtal_gain,
  input wire logic       slow_osc_en,
  input wire logic       first_pin_io_free,
  input wire logic       second_pin_io_free,
  input wire logic       second_pin_out,
  input wire logic       second_pin_oe_n,
  input wire logic       sys_clk_out,
  input wire logic       slow_tick
);
  logic [2:0] rise_r;

  function automatic logic [1:0] gain_of(input logic [2:0] m);
    case (m)
      3'h0: gain_of = cks_pkg::GAIN_LOW;
      3'h1: gain_of = cks_pkg::GAIN_MED;
      3'h2: gain_of = cks_pkg::GAIN_HIGH;
      default: gain_of = cks_pkg::GAIN_OFF;
    endcase
  endfunction

  // system clock rises since the last reference output edge
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      rise_r <= 3'h0;
    else if ($changed(second_pin_out))
      rise_r <= {2'h0, $rose(sys_clk_out)};
    else if ($rose(sys_clk_out) && rise_r != 3'h7)
      rise_r <= rise_r + 3'h1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_cfg;
    reg_rd && reg_addr == cks_pkg::ADDR_CFG |=> reg_rdata == fuse_word;
  endproperty
  a_cfg: assert property (p_cfg) else $error("fuse readback wrong");
  property p_div4;
    $changed(second_pin_out) && !second_pin_oe_n && $past(!second_pin_oe_n)
      |-> rise_r == 3'h2;
  endproperty
  a_div4: assert property (p_div4) else $error("reference output not clock/4");
  property p_io_oe;
    second_pin_io_free |-> second_pin_oe_n;
  endproperty
  a_io_oe: assert property (p_io_oe) else $error("io pin driven");
  property p_intck;
    (fuse_word[2:0] == 3'h4) [*4] |-> first_pin_io_free && !second_pin_oe_n;
  endproperty
  a_intck: assert property (p_intck) else $error("clock_output_pin mode pins wrong");
  property p_gain;
    $stable(fuse_word) [*4] |-> xtal_gain == gain_of(fuse_word[2:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("crystal gain wrong");
  property p_slow_en;
    (fuse_word[6:4] != 3'h0) [*5] |-> slow_osc_en;
  endproperty
  a_slow_en: assert property (p_slow_en) else $error("slow oscillator off");
  property p_tick;
    slow_tick |-> $past(slow_osc_en) ##1 !slow_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("slow tick malformed");

  c_clock_output_pin: cover property ($fell(second_pin_oe_n));
  c_tick: cover property (slow_tick);
  c_cfg: cover property (reg_rd && reg_addr == cks_pkg::ADDR_CFG);
endmodule

bind cks_clock_ctrl cks_clock_ctrl_checker u_chk (
  .core_clk(core_clk), .rst(rst), .fuse_word(fuse_word), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xtal_gain(xtal_gain),
  .slow_osc_en(slow_osc_en), .first_pin_io_free(first_pin_io_free),
  .second_pin_io_free(second_pin_io_free), .second_pin_out(second_pin_out),
  .second_pin_oe_n(second_pin_oe_n), .sys_clk_out(sys_clk_out), .slow_tick(slow_tick));

//--- cks_osc_model.sv
// oscillators and external clock source facing the block
// assumes a stopped source holds its last level
`timescale 1ns/1ps
module cks_osc_model #(
  parameter int EXT_HALF  = 140,
  parameter int FAST_HALF = 62,
  parameter int SLOW_HALF = 1600
) (
  // run requests
  input  wire logic ext_run,
  input  wire logic fast_osc_en,
  input  wire logic slow_osc_en,
  // oscillator levels
  output logic      ext_clk_in,
  output logic      fast_osc_in,
  output logic      slow_osc_in
);
  initial
  begin
    ext_clk_in = 1'b0;
    forever #(EXT_HALF) if (ext_run) ext_clk_in = !ext_clk_in;
  end
  initial
  begin
    fast_osc_in = 1'b0;
    forever #(FAST_HALF) if (fast_osc_en) fast_osc_in = !fast_osc_in;
  end
  initial
  begin
    slow_osc_in = 1'b0;
    forever #(SLOW_HALF) if (slow_osc_en) slow_osc_in = !slow_osc_in;
  end
endmodule

//--- testbench.sv
// self-checking bench for the clock control block
// assumes the bound checker and the oscillator model
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst, reg_wr, reg_rd, ext_run, eci, fci, sci;
  logic fen, sen, p1f, p2f, p2o, p2oe_n, sclk, stk, irq;
  logic [7:0] fuse_word, reg_wdata, reg_rdata, rv, f;
  logic [2:0] reg_addr;
  logic [1:0] gain;
  int bad_count = 0, n_compared = 0, seed = 27, cyc = 0, n;

  cks_clock_ctrl DUT (.core_clk(core_clk), .rst(rst), .fuse_word(fuse_word),
    .ext_clk_in(eci), .fast_osc_in(fci), .slow_osc_in(sci), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xtal_gain(gain), .fast_osc_en(fen), .slow_osc_en(sen), .first_pin_io_free(p1f),
    .second_pin_io_free(p2f), .second_pin_out(p2o), .second_pin_oe_n(p2oe_n),
    .sys_clk_out(sclk), .slow_tick(stk), .irq(irq));
  cks_osc_model u_osc (.ext_run(ext_run), .fast_osc_en(fen), .slow_osc_en(sen),
    .ext_clk_in(eci), .fast_osc_in(fci), .slow_osc_in(sci));

  always #20 core_clk = !core_clk;

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic boot(input logic [7:0] fw);
    @(posedge core_clk);
    rst <= 1'b1;
    fuse_word <= fw;
    ext_run <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  // polls the status register until the masked bits match
  task automatic waitfor(input logic [7:0] msk, input logic [7:0] val);
    n = 0;
    rd(cks_pkg::ADDR_STATUS, rv);
    while ((rv & msk) !== val && n < 4000)
    begin
      rd(cks_pkg::ADDR_STATUS, rv);
      n += 2;
    end
  endtask

  function automatic logic [7:0] pins_of(input logic [2:0] m);
    logic [1:0] g;
    g = m < 3'h3 ? 2'(m + 3'h1) : 2'h0;
    pins_of = {3'h0, m == 3'h3 || m == 3'h4, m == 3'h3 || m == 3'h5 || m == 3'h6,
               !(m == 3'h4 || m == 3'h7), g};
  endfunction

  initial
  begin
    time t0;
    {core_clk, rst, reg_wr, reg_rd, ext_run, reg_addr} = 8'h48;
    {fuse_word, reg_wdata} = 16'h0000;
    ////////////////////////////////////////////////////////////////////
    // every mode with random enables in the upper fuse bits
    for (int m = 0; m < 8; m++)
    begin
      f = 8'($random(seed)) & 8'h78 | 8'(m);
      boot(f);
      rd(cks_pkg::ADDR_CFG, rv);
      chk("cfg", f, rv);
      chk("pins", pins_of(3'(m)), {3'h0, p1f, p2f, p2oe_n, gain});
      if (f[6:4] != 3'h0)
        chk("slow_en", 8'h01, {7'h0, sen});
      rd(cks_pkg::ADDR_CTRL, rv);
      chk("internal_freq_select_reset", 8'h06, {5'h0, rv[6:4]});
    end
    rd(3'h7, rv);
    chk("unmapped", 8'h00, rv);
    for (int i = 0; i < 4; i++)
    begin
      f = 8'($random(seed));
      wr(cks_pkg::ADDR_IRQ_MASK, f);
      rd(cks_pkg::ADDR_IRQ_MASK, rv);
      chk("mask", f & 8'h07, rv & 8'h07);
    end
    ////////////////////////////////////////////////////////////////////
    // postscaler change, interrupt, then move to the slow oscillator
    boot(8'h04);
    wr(cks_pkg::ADDR_IRQ_MASK, 8'h02);
    wr(cks_pkg::ADDR_CTRL, 8'h50);
    waitfor(8'h02, 8'h00);
    chk("quick", 8'h01, 8'(n < 30));
    repeat (3) @(negedge core_clk);
    chk("irq_set", 8'h01, {7'h0, irq});
    @(posedge sclk);
    t0 = $time;
    repeat (4) @(posedge sclk);
    n = int'(($time - t0) / 40);
    chk("period", 8'h01, 8'(n >= 47 && n <= 51));
    wr(cks_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("irq_mask", 8'h00, {7'h0, irq});
    wr(cks_pkg::ADDR_IRQ_MASK, 8'h02);
    wr(cks_pkg::ADDR_IRQ_STS, 8'h02);
    rd(cks_pkg::ADDR_IRQ_STS, rv);
    chk("irq_clear", 8'h00, {7'h0, rv[1], irq});
    wr(cks_pkg::ADDR_CTRL, 8'h00);
    waitfor(8'h02, 8'h00);
    chk("start_delay", 8'h01, 8'(n >= 1200));
    rd(cks_pkg::ADDR_CTRL, rv);
    chk("flags", 8'h04, rv & 8'h0c);
    chk("fast_off", 8'h00, {7'h0, fen});
    ////////////////////////////////////////////////////////////////////
    // driven clock with monitor: select bit, then lose the clock
    boot(8'h15);
    waitfor(8'h01, 8'h01);
    chk("ext", 8'h01, rv & 8'h01);
    wr(cks_pkg::ADDR_CTRL, 8'h61);
    waitfor(8'h03, 8'h00);
    chk("int_sel", 8'h00, rv & 8'h01);
    wr(cks_pkg::ADDR_CTRL, 8'h60);
    waitfor(8'h01, 8'h01);
    ext_run <= 1'b0;
    waitfor(8'h07, 8'h04);
    chk("fail", 8'h04, rv & 8'h07);
    rd(cks_pkg::ADDR_IRQ_STS, rv);
    chk("fail_sts", 8'h01, rv & 8'h01);
    chk("fast_on", 8'h01, {7'h0, fen});
    complete_run();
  end
endmodule
